// file: logic/comparator_control_logic.sv
// comparator control, status, interrupt and pin-share logic with an AXI4-Lite slave
`timescale 1ns/1ps
`include "comparator_consts.svh"

// Summary of operation
// - control bit 6 powers the comparator; clear means no power drawn
// - control bit 5 inverts the comparison result seen by the output bit
// - bit 4 is read-only: 1 when positive exceeds negative, reversed if inverted
// - control bit 0 applies hysteresis; it resets to one
// - the output bit may also drive a shared pin when that pin is selected
// - any change of the output bit sets the comparator interrupt flag
// - flag and its enable both set request the comparator interrupt vector
// - in sleep or idle an enabled comparator change sets the flag and wakes
// - no wake-up when the flag is already set on entering sleep or idle
// - an enabled comparator keeps running during sleep or idle
// - with comparator on, pin data reads zero if port control one, else port data
// - pull-high on a comparator input pin is removed while that pin is selected
module comparator_control_logic
    import comparator_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PINS = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // analog comparator
    input wire logic raw_compare,
    output analog_ctrl_type analog_ctrl,
    // shared pin data reads
    input wire logic [PINS-1:0] port_control_bits,
    input wire logic [PINS-1:0] port_data_bits,
    output logic [PINS-1:0] io_read_data,
    // core power state and requests
    input wire logic sleep_mode,
    output logic irq,
    output logic wake_req
);
    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            ADDR_W'(`OFS_CONTROL): decode = REG_CONTROL;
            ADDR_W'(`OFS_IRQ_STATUS): decode = REG_IRQ_STATUS;
            ADDR_W'(`OFS_IRQ_MASK): decode = REG_IRQ_MASK;
            ADDR_W'(`OFS_PIN_SELECT): decode = REG_PIN_SELECT;
            ADDR_W'(`OFS_FLAG_SET): decode = REG_FLAG_SET;
            default: decode = REG_NONE;
        endcase
    endfunction

    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic enable_reg;
    logic invert_reg;
    logic hyst_reg;
    logic result_reg;
    logic flag_reg;
    logic mask_reg;
    logic [1:0] pin_sel_reg;
    logic wake_reg;
    logic [PINS-1:0] io_read_reg;
    logic raw_sync;
    logic result_next;
    logic change_event;
    logic do_write;
    logic wr_lane0;
    reg_sel_type wsel;
    reg_sel_type rsel;
    logic [7:0] control_view;

    comparator_sync #(
        .WIDTH(1)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(raw_compare),
        .sync_out(raw_sync)
    );

    // bus handshake: address and data taken in either order, answer after both
    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wsel = decode(waddr_reg);
    assign rsel = decode(araddr);
    assign wr_lane0 = do_write && wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            waddr_reg <= awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // control register; unimplemented positions have no storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= `RST_ENABLE;
            invert_reg <= `RST_INVERT;
            hyst_reg <= `RST_HYST;
        end else if (wr_lane0 && wsel == REG_CONTROL) begin
            enable_reg <= wdata_reg[`POS_ENABLE];
            invert_reg <= wdata_reg[`POS_INVERT];
            hyst_reg <= wdata_reg[`POS_HYST];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= 1'b0;
            pin_sel_reg <= 2'h0;
        end else if (wr_lane0 && wsel == REG_IRQ_MASK) begin
            mask_reg <= wdata_reg[0];
        end else if (wr_lane0 && wsel == REG_PIN_SELECT) begin
            pin_sel_reg <= wdata_reg[1:0];
        end
    end

    // output bit follows the synchronised result only while powered; frozen when off
    assign result_next = raw_sync ^ invert_reg;
    assign change_event = enable_reg && (result_next != result_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= `RST_RESULT;
        end else if (enable_reg) begin
            result_reg <= result_next;
        end
    end

    // sticky flag: hardware set and software force win over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
        end else if (change_event) begin
            flag_reg <= 1'b1;
        end else if (wr_lane0 && wsel == REG_FLAG_SET && wdata_reg[0]) begin
            flag_reg <= 1'b1;
        end else if (wr_lane0 && wsel == REG_IRQ_STATUS && wdata_reg[0]) begin
            flag_reg <= 1'b0;
        end
    end

    // wake only on a fresh flag set while asleep; a flag already high blocks it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= sleep_mode && change_event && !flag_reg;
        end
    end

    assign irq = flag_reg && mask_reg;
    assign wake_req = wake_reg;

    // analog and pin controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.power_on <= enable_reg;
            analog_ctrl.hysteresis_on <= hyst_reg;
            analog_ctrl.pin_out <= result_reg;
            analog_ctrl.pin_out_en <= pin_sel_reg[`POS_PIN_OUT];
            analog_ctrl.pull_high_off <= pin_sel_reg[`POS_PIN_IN];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    io_read_reg[gi] <= 1'b0;
                end else if (enable_reg) begin
                    io_read_reg[gi] <= port_control_bits[gi] ? 1'b0 : port_data_bits[gi];
                end else begin
                    io_read_reg[gi] <= port_data_bits[gi];
                end
            end
        end
    endgenerate
    assign io_read_data = io_read_reg;

    // read path
    always_comb begin
        control_view = 8'h00;
        control_view[`POS_ENABLE] = enable_reg;
        control_view[`POS_INVERT] = invert_reg;
        control_view[`POS_RESULT] = result_reg;
        control_view[`POS_HYST] = hyst_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= (rsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            case (rsel)
                REG_CONTROL: rdata_reg <= {24'h00_0000, control_view};
                REG_IRQ_STATUS: rdata_reg <= {31'h0000_0000, flag_reg};
                REG_IRQ_MASK: rdata_reg <= {31'h0000_0000, mask_reg};
                REG_PIN_SELECT: rdata_reg <= {30'h0000_0000, pin_sel_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // checks
    a_power_follows_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 analog_ctrl.power_on == $past(enable_reg))
        else $error("comparator power does not follow enable bit");

    a_result_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_reg ##1 enable_reg |-> result_reg == ($past(raw_sync) ^ $past(invert_reg)))
        else $error("output bit does not match polarity and result");

    a_result_frozen_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable_reg |=> $stable(result_reg))
        else $error("output bit changed while comparator off");

    a_hyst_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wsel == REG_CONTROL |=> hyst_reg == $past(wdata_reg[0]))
        else $error("hysteresis bit not written");

    a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_sel_reg[0] ##1 pin_sel_reg[0] |-> analog_ctrl.pin_out_en
            && analog_ctrl.pin_out == $past(result_reg))
        else $error("selected output pin not driven with result");

    a_change_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(result_reg) |-> flag_reg)
        else $error("output change did not set flag");

    a_vector_request: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (flag_reg && mask_reg))
        else $error("interrupt request mismatch");

    a_wake_on_change: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_mode && change_event && !flag_reg |=> wake_req ##1 !wake_req)
        else $error("no wake pulse on change in sleep");

    a_no_wake_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_reg |=> !wake_req)
        else $error("wake raised with flag already set");

    a_pin_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_reg && port_control_bits[0] |=> io_read_data[0] == 1'b0)
        else $error("pin read not zero with comparator on");

    a_pull_high_off: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_sel_reg[1] [*2] |-> analog_ctrl.pull_high_off)
        else $error("pull-high left on for selected input pin");

    a_unused_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        control_view[7] == 1'b0 && control_view[3:1] == 3'h0)
        else $error("unimplemented control bits read nonzero");
endmodule

// file: shared/comparator_consts.svh
// offsets, bit positions and reset values of the comparator control block
`ifndef COMPARATOR_CONSTS_SVH
`define COMPARATOR_CONSTS_SVH
`define OFS_CONTROL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_PIN_SELECT 8'h0C
`define OFS_FLAG_SET 8'h10
`define POS_ENABLE 6
`define POS_INVERT 5
`define POS_RESULT 4
`define POS_HYST 0
`define POS_PIN_OUT 0
`define POS_PIN_IN 1
`define RST_ENABLE 1'h0
`define RST_INVERT 1'h0
`define RST_RESULT 1'h0
`define RST_HYST 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: shared/comparator_pkg.sv
// types shared by the comparator control block
package comparator_pkg;
    typedef enum logic [2:0] {
        REG_CONTROL = 3'h0,
        REG_IRQ_STATUS = 3'h1,
        REG_IRQ_MASK = 3'h2,
        REG_PIN_SELECT = 3'h3,
        REG_FLAG_SET = 3'h4,
        REG_NONE = 3'h7
    } reg_sel_type;

    typedef struct packed {
        logic power_on;
        logic hysteresis_on;
        logic pin_out;
        logic pin_out_en;
        logic pull_high_off;
    } analog_ctrl_type;
endpackage

// file: logic/comparator_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module comparator_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a new level is accepted only once the last two stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_out <= '0;
        end else if (stage2_reg == stage3_reg) begin
            sync_out <= stage3_reg;
        end
    end
endmodule

// file: test/analog_inputs_model.sv
// behavioural model of the analog comparator core and its two input voltages
`timescale 1ns/1ps
module analog_inputs_model #(
    parameter int HYST_MV = 20
) (
    // clock and controls from the block
    input wire logic aclk,
    input wire logic power_on,
    input wire logic hysteresis_on,
    // input voltages in millivolts
    input wire logic signed [31:0] pos_mv,
    input wire logic signed [31:0] neg_mv,
    // comparison result
    output logic raw_compare
);
    logic state = 1'b0;
    int margin;
    always @(posedge aclk) begin
        margin = hysteresis_on ? HYST_MV : 0;
        if (!power_on) begin
            // an unpowered comparator output carries no information
            state <= ~state;
        end else if (pos_mv > neg_mv + margin) begin
            state <= 1'b1;
        end else if (pos_mv < neg_mv - margin) begin
            state <= 1'b0;
        end
    end
    assign raw_compare = state;
endmodule

// file: test/comparator_control_logic_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "comparator_consts.svh"
module comparator_control_logic_bench;
    import comparator_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, raw_compare, irq, wake_req;
    logic [1:0] bresp, rresp, r, io_read_data;
    logic [1:0] port_control_bits = 2'h0, port_data_bits = 2'h0;
    logic sleep_mode = 1'b0;
    analog_ctrl_type analog_ctrl;
    int pos_mv = 0, neg_mv = 500, err_count = 0, num_checks = 0, wake_count = 0;
    logic cur_gt = 1'b0, prev, g;

    always #50 aclk = ~aclk;

    comparator_control_logic DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .raw_compare(raw_compare), .analog_ctrl(analog_ctrl),
        .port_control_bits(port_control_bits), .port_data_bits(port_data_bits),
        .io_read_data(io_read_data), .sleep_mode(sleep_mode), .irq(irq),
        .wake_req(wake_req));

    analog_inputs_model partner (.aclk(aclk), .power_on(analog_ctrl.power_on),
        .hysteresis_on(analog_ctrl.hysteresis_on), .pos_mv(pos_mv), .neg_mv(neg_mv),
        .raw_compare(raw_compare));

    always @(posedge aclk) begin
        if (wake_req === 1'b1) wake_count++;
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_ctrl(logic en, logic inv, logic hy, logic gt);
        return {25'h0, en, inv, gt ^ inv, 3'h0, hy};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                dat = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] rs;
        wr(a, dat, rs);
        check_word({30'h0, rs}, {30'h0, `RESP_OKAY});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dat;
        logic [1:0] rs;
        rd(a, dat, rs);
        check_word(dat, exp);
        check_word({30'h0, rs}, {30'h0, `RESP_OKAY});
    endtask

    // drive the inputs well clear of the hysteresis band, then let the result settle
    task automatic set_in(input logic gt);
        @(posedge aclk);
        cur_gt = gt;
        pos_mv <= gt ? 600 + int'($urandom_range(300)) : int'($urandom_range(400));
        repeat (10) @(posedge aclk);
    endtask

    task automatic pin_loop(input logic en);
        logic [1:0] c, p;
        for (int i = 0; i < 8; i++) begin
            c = 2'($urandom);
            p = 2'($urandom);
            @(posedge aclk);
            port_control_bits <= c;
            port_data_bits <= p;
            repeat (3) @(posedge aclk);
            check_word({30'h0, io_read_data}, {30'h0, en ? (p & ~c) : p});
        end
    endtask

    initial begin
        #(20000 * 100);
        err_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(28993));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check_word({27'h0, analog_ctrl}, 32'h08);
        rchk(`OFS_CONTROL, 32'h01);
        rd(8'h14, d, r);
        check_word({30'h0, r}, {30'h0, `RESP_SLVERR});
        check_word(d, 32'h0000_0000);
        wr(8'h14, 32'hFFFF_FFFF, r);
        check_word({30'h0, r}, {30'h0, `RESP_SLVERR});
        rchk(`OFS_CONTROL, 32'h01);
        wreg(`OFS_IRQ_MASK, 32'h1);
        set_in(1'b1);
        wreg(`OFS_CONTROL, 32'hFF);
        repeat (10) @(posedge aclk);
        rchk(`OFS_CONTROL, exp_ctrl(1'b1, 1'b1, 1'b1, 1'b1));
        check_bit(analog_ctrl.power_on, 1'b1);
        wreg(`OFS_IRQ_STATUS, 32'h1);
        wreg(`OFS_CONTROL, 32'h41);
        repeat (10) @(posedge aclk);
        rchk(`OFS_CONTROL, exp_ctrl(1'b1, 1'b0, 1'b1, 1'b1));
        rchk(`OFS_IRQ_STATUS, 32'h1);
        check_bit(irq, 1'b1);
        wreg(`OFS_IRQ_STATUS, 32'h1);
        check_bit(irq, 1'b0);
        for (int i = 0; i < 8; i++) begin
            prev = cur_gt;
            g = 1'($urandom_range(1));
            set_in(g);
            rchk(`OFS_CONTROL, exp_ctrl(1'b1, 1'b0, 1'b1, g));
            rchk(`OFS_IRQ_STATUS, {31'h0, g != prev});
            wreg(`OFS_IRQ_STATUS, 32'h1);
        end
        wreg(`OFS_IRQ_MASK, 32'h0);
        wreg(`OFS_FLAG_SET, 32'h1);
        check_bit(irq, 1'b0);
        wreg(`OFS_IRQ_STATUS, 32'h1);
        @(posedge aclk);
        sleep_mode <= 1'b1;
        wake_count = 0;
        set_in(!cur_gt);
        check_word(32'(wake_count), 32'h1);
        rchk(`OFS_IRQ_STATUS, 32'h1);
        wreg(`OFS_IRQ_STATUS, 32'h1);
        wreg(`OFS_FLAG_SET, 32'h1);
        rchk(`OFS_IRQ_STATUS, 32'h1);
        set_in(!cur_gt);
        check_word(32'(wake_count), 32'h1);
        wreg(`OFS_IRQ_STATUS, 32'h1);
        sleep_mode <= 1'b0;
        wreg(`OFS_PIN_SELECT, 32'h3);
        repeat (3) @(posedge aclk);
        check_bit(analog_ctrl.pin_out_en, 1'b1);
        check_bit(analog_ctrl.pin_out, cur_gt);
        check_bit(analog_ctrl.pull_high_off, 1'b1);
        pin_loop(1'b1);
        wreg(`OFS_CONTROL, 32'h00);
        repeat (3) @(posedge aclk);
        check_bit(analog_ctrl.power_on, 1'b0);
        check_bit(analog_ctrl.hysteresis_on, 1'b0);
        pin_loop(1'b0);
        end_of_test();
    end
endmodule
